// ---- verilog/udc_pkg.sv ----
// shared constants and carriers for the four-bit dual-input up/down counter
`default_nettype none

package udc_pkg;

  // ---------------------------------------------------------------
  // counter geometry and values
  // ---------------------------------------------------------------
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam int SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // every pin that the far side drives, in one bundle
  typedef struct packed {
    logic clear;
    logic load_n;
    logic up;
    logic down;
    logic [3:0] data;
  } udc_pins_t;

  // idle levels: count inputs and load high, clear low
  localparam udc_pins_t PINS_RST = '{clear: 1'b0, load_n: 1'b1, up: 1'b1, down: 1'b1,
                                     data: 4'h0};

  // one-cycle count events seen by the core
  typedef struct packed {
    logic up;
    logic down;
  } udc_evt_t;

  // synchroniser state: three stages and the filtered result
  typedef struct packed {
    udc_pins_t s1;
    udc_pins_t s2;
    udc_pins_t s3;
    udc_pins_t filt;
  } udc_sync_st_t;

  // counter core state
  typedef struct packed {
    logic [3:0] cnt;
    logic up_prev;
    logic down_prev;
  } udc_core_st_t;

  localparam udc_core_st_t CORE_RST = '{cnt: 4'h0, up_prev: 1'b1, down_prev: 1'b1};

endpackage

`default_nettype wire

// ---- verilog/udc_sync.sv ----
// three-stage input synchroniser with agreement filter for all far-side pins
`default_nettype none

module udc_sync (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire udc_pkg::udc_pins_t pins_i,
  output udc_pkg::udc_pins_t filt_o
);

  udc_pkg::udc_sync_st_t st_reg;
  udc_pkg::udc_sync_st_t st_next;
  udc_pkg::udc_pins_t filt_nx;

  // ---------------------------------------------------------------
  // agreement filter
  // ---------------------------------------------------------------
  // a bit changes only once stages two and three agree; stage one is never read here
  for (genvar i = 0; i < $bits(udc_pkg::udc_pins_t); i++) begin : g_filt
    assign filt_nx[i] = (st_reg.s2[i] == st_reg.s3[i]) ? st_reg.s2[i] : st_reg.filt[i];
  end

  // next state: shift the chain, freeze everything while ce_i is low
  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.s1 = pins_i;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.filt = filt_nx;
    end
  end

  // state register, reset to idle pin levels
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{s1: udc_pkg::PINS_RST, s2: udc_pkg::PINS_RST, s3: udc_pkg::PINS_RST,
                  filt: udc_pkg::PINS_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign filt_o = st_reg.filt;

endmodule

`default_nettype wire

// ---- verilog/udc_core.sv ----
// counter core: edge detection on the count inputs and the four-bit count register
`default_nettype none

module udc_core (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire udc_pkg::udc_pins_t filt_i,
  output udc_pkg::udc_evt_t evt_o,
  output logic [3:0] cnt_o
);

  udc_pkg::udc_core_st_t st_reg;
  udc_pkg::udc_core_st_t st_next;
  udc_pkg::udc_evt_t evt;

  // ---------------------------------------------------------------
  // edge steering
  // ---------------------------------------------------------------
  // a rising edge counts only while the other input rests high; both rising at once
  // breaks the driver's contract and fires both events; the core takes it as an up step
  always_comb begin
    evt.up = filt_i.up && !st_reg.up_prev && filt_i.down;
    evt.down = filt_i.down && !st_reg.down_prev && filt_i.up;
  end

  // next count: clear, then load, then count edges, else hold
  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.up_prev = filt_i.up;
      st_next.down_prev = filt_i.down;
      if (filt_i.clear) begin
        st_next.cnt = udc_pkg::CNT_ZERO;
      end else if (!filt_i.load_n) begin
        st_next.cnt = filt_i.data;
      end else if (evt.up) begin
        st_next.cnt = st_reg.cnt + udc_pkg::CNT_STEP;
      end else if (evt.down) begin
        st_next.cnt = st_reg.cnt - udc_pkg::CNT_STEP;
      end
    end
  end

  // all four bits in one register on one clock: no ripple between bits
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= udc_pkg::CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cnt_o = st_reg.cnt;
  assign evt_o = evt;

endmodule

`default_nettype wire

// ---- verilog/udc_top.sv ----
// top of the four-bit dual-input up/down counter: pin overrides, carry and borrow
`default_nettype none

module udc_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic count_up_i,
  input wire logic count_down_i,
  input wire logic load_n_i,
  input wire logic async_clear_i,
  input wire logic [3:0] data_i,
  output logic [3:0] q_o,
  output logic carry_out_n_o,
  output logic borrow_out_n_o
);

  udc_pkg::udc_pins_t pins;
  udc_pkg::udc_pins_t filt;
  udc_pkg::udc_evt_t evt;
  logic [3:0] cnt;

  // true while the visible count sits at the given terminal value
  function automatic logic at_value(input logic [3:0] v, input logic [3:0] term);
    at_value = (v == term);
  endfunction

  // ---------------------------------------------------------------
  // input capture
  // ---------------------------------------------------------------
  // every far-side pin is asynchronous to mclk_i and goes through the synchroniser
  always_comb begin
    pins.clear = async_clear_i;
    pins.load_n = load_n_i;
    pins.up = count_up_i;
    pins.down = count_down_i;
    pins.data = data_i;
  end

  udc_sync u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pins_i(pins),
    .filt_o(filt)
  );

  udc_core u_core (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .filt_i(filt),
    .evt_o(evt),
    .cnt_o(cnt)
  );

  // ---------------------------------------------------------------
  // output overrides
  // ---------------------------------------------------------------
  // clear and load act on the outputs straight from the pins, so they need no clock;
  // the register catches up five cycles later and agrees by then
  always_comb begin
    if (async_clear_i) begin
      q_o = udc_pkg::CNT_ZERO;
    end else if (!load_n_i) begin
      q_o = data_i;
    end else begin
      q_o = cnt;
    end
  end

  // cascade outputs are pure gating of the count and the raw input level, so a
  // following stage sees the pulse with no register delay
  assign carry_out_n_o = !(at_value(q_o, udc_pkg::CNT_MAX) && !count_up_i);
  assign borrow_out_n_o = !(at_value(q_o, udc_pkg::CNT_ZERO) && !count_down_i);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic idle_ctl;
  assign idle_ctl = !filt.clear && filt.load_n;

  chk_up_step: assert property (
    ce_i && idle_ctl && evt.up |=> cnt == $past(cnt) + udc_pkg::CNT_STEP)
    else $error("count did not step up after an up edge");

  chk_down_step: assert property (
    ce_i && idle_ctl && evt.down |=> cnt == $past(cnt) - udc_pkg::CNT_STEP)
    else $error("count did not step down after a down edge");

  chk_edge_only: assert property (
    ce_i && (cnt != $past(cnt)) |-> $past(evt.up || evt.down || filt.clear || !filt.load_n))
    else $error("count changed without an edge, clear or load");

  chk_hold_idle: assert property (
    ce_i && idle_ctl && !evt.up && !evt.down |=> $stable(cnt))
    else $error("count moved while idle");

  chk_freeze_ce: assert property (
    !ce_i |=> $stable(cnt))
    else $error("count moved while clock enable low");

  chk_clear_out: assert property (
    async_clear_i |-> q_o == udc_pkg::CNT_ZERO)
    else $error("outputs not zero during clear");

  chk_clear_prio: assert property (
    ce_i && filt.clear && !filt.load_n |=> cnt == udc_pkg::CNT_ZERO)
    else $error("load overrode clear");

  chk_load_out: assert property (
    !async_clear_i && !load_n_i |-> q_o == data_i)
    else $error("outputs not following data during load");

  chk_load_reg: assert property (
    ce_i && !filt.clear && !filt.load_n |=> cnt == $past(filt.data))
    else $error("preset not taken into the count");

  chk_carry_low: assert property (
    !carry_out_n_o |-> q_o == udc_pkg::CNT_MAX && !count_up_i)
    else $error("carry low outside terminal up count");

  chk_borrow_low: assert property (
    !borrow_out_n_o |-> q_o == udc_pkg::CNT_ZERO && !count_down_i)
    else $error("borrow low outside terminal down count");

  chk_wrap_up: assert property (
    ce_i && idle_ctl && evt.up && cnt == udc_pkg::CNT_MAX |=> cnt == udc_pkg::CNT_ZERO)
    else $error("up count did not wrap to zero");

  chk_wrap_down: assert property (
    ce_i && idle_ctl && evt.down && cnt == udc_pkg::CNT_ZERO |=> cnt == udc_pkg::CNT_MAX)
    else $error("down count did not wrap to fifteen");

  cov_up_wrap: cover property (ce_i && evt.up && cnt == udc_pkg::CNT_MAX ##1 cnt == 4'h0);
  cov_down_wrap: cover property (ce_i && evt.down && cnt == 4'h0 ##1 cnt == 4'hF);
  cov_load: cover property (!filt.load_n && filt.data == 4'hD ##1 cnt == 4'hD);
  cov_clear: cover property (filt.clear ##1 cnt == udc_pkg::CNT_ZERO);

endmodule

`default_nettype wire

// ---- tb/udc_far_end.sv ----
// far-side driver model: pulses one count pin while the other stays high
`default_nettype none

module udc_far_end (
  input wire logic mclk_i,
  output logic up_o,
  output logic down_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  // both count pins rest high, so no level is ever mistaken for an edge
  initial begin
    up_o = 1'b1;
    down_o = 1'b1;
  end

  // ---------------------------------------------------------------
  // pin moves
  // ---------------------------------------------------------------
  // drop one pin; the idle pin is never touched, so it stays high
  task automatic press(input logic dir_up);
    @(posedge mclk_i);
    #2;
    if (dir_up) begin
      up_o = 1'b0;
    end else begin
      down_o = 1'b0;
    end
  endtask

  // the rising edge here is what makes the counter step
  task automatic lift();
    @(posedge mclk_i);
    #2;
    up_o = 1'b1;
    down_o = 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- tb/four_bit_dual_clock_updown_counter_bench.sv ----
// self-checking bench for the four-bit dual-input up/down counter
`default_nettype none

module four_bit_dual_clock_updown_counter_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic load_n = 1'b1;
  logic clr = 1'b0;
  logic [3:0] data = 4'h0;
  logic up;
  logic down;
  logic [3:0] q;
  logic carry_n;
  logic borrow_n;
  int error_cnt = 0;
  int compares = 0;

  // ---------------------------------------------------------------
  // clock, far side and design
  // ---------------------------------------------------------------
  initial forever #12.5 mclk = ~mclk;

  udc_far_end udc_far_end_inst (.mclk_i(mclk), .up_o(up), .down_o(down));

  udc_top udc_top_inst (
    .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .count_up_i(up), .count_down_i(down),
    .load_n_i(load_n), .async_clear_i(clr), .data_i(data), .q_o(q),
    .carry_out_n_o(carry_n), .borrow_out_n_o(borrow_n)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // one count pulse; flags are looked at in the very cycle the pin drops,
  // since they must not wait for any flop
  task automatic step(input logic dir_up, input logic [3:0] prev, input logic [3:0] exp);
    udc_far_end_inst.press(dir_up);
    #1;
    check("carry", {3'h0, carry_n}, {3'h0, !(dir_up && prev == 4'hF)});
    check("borrow", {3'h0, borrow_n}, {3'h0, !(!dir_up && prev == 4'h0)});
    tick(5);
    check("q on falling pin", q, prev);
    udc_far_end_inst.lift();
    tick(7);
    check("q after rise", q, exp);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_clear();
    clr = 1'b1;
    load_n = 1'b0;
    data = 4'h5;
    #1;
    check("q under clear", q, 4'h0);
    tick(6);
    load_n = 1'b1;
    step(1'b1, 4'h0, 4'h0);
    clr = 1'b0;
    tick(6);
    check("q after clear", q, 4'h0);
    $display("test_clear done");
  endtask

  task automatic test_load();
    load_n = 1'b0;
    data = 4'hD;
    #1;
    check("q under load", q, 4'hD);
    tick(6);
    load_n = 1'b1;
    tick(8);
    check("q held after load", q, 4'hD);
    $display("test_load done");
  endtask

  task automatic test_up();
    step(1'b1, 4'hD, 4'hE);
    step(1'b1, 4'hE, 4'hF);
    step(1'b1, 4'hF, 4'h0);
    step(1'b1, 4'h0, 4'h1);
    step(1'b1, 4'h1, 4'h2);
    $display("test_up done");
  endtask

  task automatic test_down();
    step(1'b0, 4'h2, 4'h1);
    step(1'b0, 4'h1, 4'h0);
    step(1'b0, 4'h0, 4'hF);
    step(1'b0, 4'hF, 4'hE);
    step(1'b0, 4'hE, 4'hD);
    $display("test_down done");
  endtask

  // a full pulse while the clock enable is low must leave no trace, even after the
  // enable returns, since the synchroniser was frozen with the idle level inside
  task automatic test_freeze();
    ce = 1'b0;
    udc_far_end_inst.press(1'b0);
    #1;
    check("borrow frozen", {3'h0, borrow_n}, 4'h1);
    udc_far_end_inst.lift();
    tick(4);
    check("q frozen", q, 4'hD);
    ce = 1'b1;
    tick(8);
    check("q after thaw", q, 4'hD);
    $display("test_freeze done");
  endtask

  // ---------------------------------------------------------------
  // verdict
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // the whole run is about two hundred cycles; this limit is ample
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge mclk);
    #2;
    rst = 1'b0;
    tick(2);
    test_clear();
    test_load();
    test_up();
    test_down();
    test_freeze();
    tally_and_finish();
  end
endmodule

`default_nettype wire
